// >>> fcm_dev.sv
// Flash mode control and command recognition front end of the array.
// Assumes rst_n is the CPU reset and the array sequencer answers on the arr_ ports.
`timescale 1ns/10ps
`include "fcm_cfg.svh"
module fcm_dev #(
    parameter int PAGE_WORDS = 128,
    parameter int NUM_BLOCKS = 8,
    parameter int BLK_SHIFT = 15
) (
    input wire logic clk,
    input wire logic rst_n,
    fcm_if.dev bus,
    output logic arr_rd_en,
    output logic [31:0] arr_rd_addr,
    input wire logic [31:0] arr_rdata,
    output logic arr_wvalid,
    output logic [31:0] arr_waddr,
    output logic [31:0] arr_wdata,
    output logic arr_start,
    output fcm_pkg::fcm_op_t arr_op,
    output logic [31:0] arr_addr,
    input wire logic arr_done,
    input wire logic arr_fail
);
    localparam int BLK_W = $clog2(NUM_BLOCKS);
    localparam int CNT_W = $clog2(PAGE_WORDS + 1);

    typedef enum logic [5:0] {
        FCM_ST_READ = 6'h01,
        FCM_ST_SEQ = 6'h02,
        FCM_ST_ID = 6'h04,
        FCM_ST_LOAD = 6'h08,
        FCM_ST_BUSY = 6'h10,
        FCM_ST_FAIL = 6'h20
    } fcm_dev_state_t;

    fcm_dev_state_t state;
    fcm_dev_state_t next_state;
    logic [2:0] pos;
    logic [2:0] next_pos;
    logic [31:0] cmd_data;
    logic [31:0] next_cmd_data;
    logic [CNT_W-1:0] cnt;
    logic [31:0] page_top;
    logic [3:0] prot_code [NUM_BLOCKS];
    logic rd_pend;
    logic rd_mode_arr;
    logic rd_mode_id;
    logic next_start;
    fcm_pkg::fcm_op_t next_op;
    logic [31:0] next_addr;

    // Decode of the incoming write against the expected step of a sequence.
    wire wr = bus.wr_valid && bus.wr_word;
    wire [31:0] a_off = bus.wr_addr & `FCM_ADDR_MASK;
    wire at_u1 = (a_off == `FCM_UNLOCK1_ADDR);
    wire at_u2 = (a_off == `FCM_UNLOCK2_ADDR);
    wire d_u1 = (bus.wr_data == `FCM_D_UNLOCK1);
    wire d_u2 = (bus.wr_data == `FCM_D_UNLOCK2);
    wire is_read_cmd = wr && (bus.wr_data == `FCM_D_READ);
    wire d_cmd = (bus.wr_data == `FCM_D_PROG) || (bus.wr_data == `FCM_D_ERASE) ||
        (bus.wr_data == `FCM_D_IDREAD) || (bus.wr_data == `FCM_D_PROT);
    wire kind_erase = (cmd_data == `FCM_D_ERASE);
    wire kind_prot = (cmd_data == `FCM_D_PROT);
    wire last_chip = kind_erase && at_u1 && (bus.wr_data == `FCM_D_CHIP);
    wire last_block = kind_erase && (bus.wr_data == `FCM_D_BLOCK);
    wire last_prot = kind_prot && (bus.wr_data == `FCM_D_PROT);
    wire [BLK_W-1:0] wr_blk = bus.wr_addr[BLK_SHIFT +: BLK_W];
    wire [BLK_W-1:0] pg_blk = page_top[BLK_SHIFT +: BLK_W];
    wire [BLK_W-1:0] op_blk = arr_addr[BLK_SHIFT +: BLK_W];
    wire wr_blk_prot = (prot_code[wr_blk] == `FCM_PROT_SET);
    wire pg_blk_prot = (prot_code[pg_blk] == `FCM_PROT_SET);
    wire last_word = (cnt == CNT_W'(PAGE_WORDS - 1));
    wire [31:0] word_addr = page_top + {cnt, 2'b00};
    logic all_prot;
    logic step_ok;

    // Chip erase is skipped only when every block is protected.
    always_comb begin
        all_prot = 1'b1;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            all_prot = all_prot && (prot_code[i] == `FCM_PROT_SET);
        end
    end

    // Expected address and data for each ordered write of a sequence.
    always_comb begin
        case (pos)
            3'h0: step_ok = at_u1 && d_u1;
            3'h1: step_ok = at_u2 && d_u2;
            3'h2: step_ok = at_u1 && d_cmd;
            3'h3: step_ok = (kind_erase || kind_prot) && at_u1 && d_u1;
            3'h4: step_ok = at_u2 && d_u2;
            3'h5: step_ok = last_chip || last_block || last_prot;
            default: step_ok = 1'b0;
        endcase
    end

    // Mode machine; writes that break a sequence fall back to read mode.
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_cmd_data = cmd_data;
        next_start = 1'b0;
        next_op = arr_op;
        next_addr = arr_addr;
        case (state)
            FCM_ST_READ: begin
                if (wr && !is_read_cmd && step_ok) begin
                    next_state = FCM_ST_SEQ;
                    next_pos = `FCM_POS_FIRST;
                end
            end
            FCM_ST_SEQ: begin
                if (is_read_cmd) begin
                    next_state = FCM_ST_READ;
                    next_pos = 3'h0;
                end else if (bus.wr_valid && (!bus.wr_word || !step_ok)) begin
                    next_state = FCM_ST_READ;
                    next_pos = 3'h0;
                end else if (wr && pos == `FCM_POS_CMD) begin
                    next_cmd_data = bus.wr_data;
                    next_pos = pos + 3'h1;
                    if (bus.wr_data == `FCM_D_IDREAD) begin
                        next_state = FCM_ST_ID;
                        next_pos = 3'h0;
                    end else if (bus.wr_data == `FCM_D_PROG) begin
                        next_state = FCM_ST_LOAD;
                        next_pos = 3'h0;
                    end
                end else if (wr && pos == `FCM_POS_LAST) begin
                    next_pos = 3'h0;
                    next_addr = bus.wr_addr;
                    next_op = last_chip ? fcm_pkg::FCM_OP_CHIP :
                        (last_block ? fcm_pkg::FCM_OP_BLOCK : fcm_pkg::FCM_OP_PROT);
                    // Erases of protected targets are refused and leave read mode in place.
                    if ((last_chip && all_prot) || (last_block && wr_blk_prot)) begin
                        next_state = FCM_ST_READ;
                    end else begin
                        next_state = FCM_ST_BUSY;
                        next_start = 1'b1;
                    end
                end else if (wr) begin
                    next_pos = pos + 3'h1;
                end
            end
            FCM_ST_ID: begin
                if (is_read_cmd) begin
                    next_state = FCM_ST_READ;
                end
            end
            FCM_ST_LOAD: begin
                // Software reset has no effect once page words are flowing.
                if (wr && last_word) begin
                    next_op = fcm_pkg::FCM_OP_PROG;
                    next_addr = page_top;
                    if (pg_blk_prot) begin
                        next_state = FCM_ST_READ;
                    end else begin
                        next_state = FCM_ST_BUSY;
                        next_start = 1'b1;
                    end
                end
            end
            FCM_ST_BUSY: begin
                // Writes are not looked at here: new sequences are ignored.
                if (arr_fail) begin
                    next_state = FCM_ST_FAIL;
                end else if (arr_done) begin
                    next_state = FCM_ST_READ;
                end
            end
            FCM_ST_FAIL: next_state = FCM_ST_FAIL;
            default: next_state = FCM_ST_READ;
        endcase
    end

    // Mode state; the CPU reset is the only way out of the locked state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FCM_ST_READ;
            pos <= 3'h0;
            cmd_data <= 32'h0000_0000;
            arr_start <= 1'b0;
            arr_op <= fcm_pkg::FCM_OP_PROG;
            arr_addr <= 32'h0000_0000;
        end else begin
            state <= next_state;
            pos <= next_pos;
            cmd_data <= next_cmd_data;
            arr_start <= next_start;
            arr_op <= next_op;
            arr_addr <= next_addr;
        end
    end

    // Page word collection; the first word fixes the page top address.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            page_top <= 32'h0000_0000;
            arr_wvalid <= 1'b0;
            arr_waddr <= 32'h0000_0000;
            arr_wdata <= 32'h0000_0000;
        end else begin
            arr_wvalid <= (state == FCM_ST_LOAD) && wr;
            if (state != FCM_ST_LOAD) begin
                cnt <= '0;
                page_top <= bus.wr_addr;
            end else if (wr) begin
                cnt <= cnt + CNT_W'(1);
                arr_waddr <= (cnt == '0) ? bus.wr_addr : word_addr;
                arr_wdata <= bus.wr_data;
                if (cnt == '0) begin
                    page_top <= bus.wr_addr;
                end
            end
        end
    end

    // Protection codes; a successful protect operation programs the code.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_BLOCKS; i++) begin
                prot_code[i] <= `FCM_PROT_CLEAR;
            end
        end else if (state == FCM_ST_BUSY && arr_done && !arr_fail && arr_op == fcm_pkg::FCM_OP_PROT) begin
            prot_code[op_blk] <= `FCM_PROT_SET;
        end
    end

    // Read path: two cycles, array data only in the read and sequence states.
    assign rd_mode_arr = (state == FCM_ST_READ) || (state == FCM_ST_SEQ);
    assign rd_mode_id = (state == FCM_ST_ID);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arr_rd_en <= 1'b0;
            arr_rd_addr <= 32'h0000_0000;
            rd_pend <= 1'b0;
            bus.rd_ack <= 1'b0;
            bus.rd_data <= 32'h0000_0000;
        end else begin
            arr_rd_en <= bus.rd_valid && rd_mode_arr;
            arr_rd_addr <= bus.rd_addr;
            rd_pend <= bus.rd_valid;
            bus.rd_ack <= rd_pend;
            if (rd_pend) begin
                bus.rd_data <= rd_mode_arr ? arr_rdata : (rd_mode_id ? `FCM_ID_VALUE : 32'h0000_0000);
            end
        end
    end

    // Busy while page words load, an operation runs or the array is locked.
    assign bus.ready_busy_flag = !((state == FCM_ST_LOAD) || (state == FCM_ST_BUSY) || (state == FCM_ST_FAIL));
endmodule : fcm_dev

// >>> fcm_cfg.svh
// Constants shared by both ends of the flash command-mode link.
// Assumes it is included by bare name.
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH
// Only the low offset bits take part in the address match.
`define FCM_ADDR_MASK 32'h0000_fffc
`define FCM_UNLOCK1_ADDR 32'h0000_5400
`define FCM_UNLOCK2_ADDR 32'h0000_aa00
// Command data values.
`define FCM_D_UNLOCK1 32'h0000_00aa
`define FCM_D_UNLOCK2 32'h0000_0055
`define FCM_D_READ 32'h0000_00f0
`define FCM_D_PROG 32'h0000_00a0
`define FCM_D_ERASE 32'h0000_0080
`define FCM_D_IDREAD 32'h0000_0090
`define FCM_D_PROT 32'h0000_009a
`define FCM_D_CHIP 32'h0000_0010
`define FCM_D_BLOCK 32'h0000_0030
// Sequence positions (zero based).
`define FCM_POS_CMD 3'h2
`define FCM_POS_LAST 3'h5
`define FCM_POS_FIRST 3'h1
// A block is protected when all four code bits are programmed to zero.
`define FCM_PROT_SET 4'h0
`define FCM_PROT_CLEAR 4'hf
`define FCM_WORD_STEP 32'h0000_0004
// Arbitrary identifier value returned in the identifier reading state.
`define FCM_ID_VALUE 32'h0000_5a5a
`endif

// >>> fcm_pkg.sv
// Types shared by both ends of the flash command-mode link.
// Assumes fcm_cfg.svh is on the include path.
package fcm_pkg;
    // Automatic operation handed to the array sequencer.
    typedef enum logic [1:0] {
        FCM_OP_PROG = 2'h0,
        FCM_OP_CHIP = 2'h1,
        FCM_OP_BLOCK = 2'h2,
        FCM_OP_PROT = 2'h3
    } fcm_op_t;
    // Command that the host user asks for.
    typedef enum logic [2:0] {
        FCM_H_READ = 3'h0,
        FCM_H_RESET = 3'h1,
        FCM_H_PROG = 3'h2,
        FCM_H_CHIP = 3'h3,
        FCM_H_BLOCK = 3'h4,
        FCM_H_PROT = 3'h5,
        FCM_H_ID = 3'h6
    } fcm_hcmd_t;
endpackage : fcm_pkg

// >>> fcm_if.sv
// Bus between the CPU-side command host and the flash command-mode front end.
// Assumes both ends share one clock; no tri-state wires are carried.
`timescale 1ns/10ps
interface fcm_if;
    logic wr_valid;
    logic wr_word;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic rd_valid;
    logic [31:0] rd_addr;
    logic rd_ack;
    logic [31:0] rd_data;
    logic ready_busy_flag;
    modport dev (input wr_valid, input wr_word, input wr_addr, input wr_data, input rd_valid, input rd_addr,
        output rd_ack, output rd_data, output ready_busy_flag);
    modport host (output wr_valid, output wr_word, output wr_addr, output wr_data, output rd_valid,
        output rd_addr, input rd_ack, input rd_data, input ready_busy_flag);
endinterface : fcm_if

// >>> fcm_host.sv
// CPU-side command host: turns user commands into ordered word writes.
// Assumes it runs from memory outside the array and shares clk with the device.
`timescale 1ns/10ps
`include "fcm_cfg.svh"
module fcm_host #(
    parameter int PAGE_WORDS = 128
) (
    input wire logic clk,
    input wire logic rst_n,
    fcm_if.host bus,
    input wire logic usr_req,
    input wire fcm_pkg::fcm_hcmd_t usr_cmd,
    input wire logic [31:0] usr_addr,
    output logic usr_ready,
    output logic usr_done,
    input wire logic usr_wvalid,
    input wire logic [31:0] usr_wdata,
    output logic usr_wready,
    input wire logic usr_rd_req,
    input wire logic [31:0] usr_rd_addr,
    output logic usr_rd_ack,
    output logic [31:0] usr_rd_data
);
    localparam int CNT_W = $clog2(PAGE_WORDS + 1);

    typedef enum logic [4:0] {
        FCM_HS_IDLE = 5'h01,
        FCM_HS_CHK = 5'h02,
        FCM_HS_SEQ = 5'h04,
        FCM_HS_DATA = 5'h08,
        FCM_HS_RD = 5'h10
    } fcm_host_state_t;

    fcm_host_state_t state;
    fcm_pkg::fcm_hcmd_t cmd;
    logic [31:0] taddr;
    logic [2:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [31:0] s_addr;
    logic [31:0] s_data;
    logic [2:0] s_len;

    // The first unlock word of each group sits at index 1 and index 4.
    wire first_unlock = (idx == 3'h1) || (idx == 3'h4);

    // Sequence table: index 0 is the recommended leading Read command.
    always_comb begin
        s_addr = first_unlock ? `FCM_UNLOCK1_ADDR : `FCM_UNLOCK2_ADDR;
        s_data = first_unlock ? `FCM_D_UNLOCK1 : `FCM_D_UNLOCK2;
        case (cmd)
            fcm_pkg::FCM_H_READ: s_len = 3'h1;
            fcm_pkg::FCM_H_CHIP, fcm_pkg::FCM_H_BLOCK, fcm_pkg::FCM_H_PROT: s_len = 3'h7;
            default: s_len = 3'h4;
        endcase
        if (idx == 3'h0) begin
            s_addr = taddr;
            s_data = `FCM_D_READ;
        end else if (idx == 3'h3) begin
            s_addr = `FCM_UNLOCK1_ADDR;
            case (cmd)
                fcm_pkg::FCM_H_PROG: s_data = `FCM_D_PROG;
                fcm_pkg::FCM_H_ID: s_data = `FCM_D_IDREAD;
                fcm_pkg::FCM_H_PROT: s_data = `FCM_D_PROT;
                fcm_pkg::FCM_H_RESET: s_data = `FCM_D_READ;
                default: s_data = `FCM_D_ERASE;
            endcase
        end else if (idx == 3'h6) begin
            s_addr = (cmd == fcm_pkg::FCM_H_CHIP) ? `FCM_UNLOCK1_ADDR : taddr;
            s_data = (cmd == fcm_pkg::FCM_H_CHIP) ? `FCM_D_CHIP :
                ((cmd == fcm_pkg::FCM_H_BLOCK) ? `FCM_D_BLOCK : `FCM_D_PROT);
        end
    end

    wire seq_end = (idx == s_len - 3'h1);
    wire take_word = (state == FCM_HS_DATA) && usr_wvalid;
    assign usr_ready = (state == FCM_HS_IDLE);
    assign usr_wready = (state == FCM_HS_DATA);
    assign usr_rd_ack = bus.rd_ack;
    assign usr_rd_data = bus.rd_data;

    // Host sequencing; no flash read is started while a sequence runs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FCM_HS_IDLE;
            cmd <= fcm_pkg::FCM_H_READ;
            taddr <= 32'h0000_0000;
            idx <= 3'h0;
            cnt <= '0;
            usr_done <= 1'b0;
        end else begin
            usr_done <= 1'b0;
            case (state)
                FCM_HS_IDLE: begin
                    idx <= 3'h0;
                    cnt <= '0;
                    if (usr_req) begin
                        cmd <= usr_cmd;
                        taddr <= usr_addr;
                        state <= FCM_HS_CHK;
                    end else if (usr_rd_req) begin
                        state <= FCM_HS_RD;
                    end
                end
                FCM_HS_CHK: begin
                    if (bus.ready_busy_flag) begin
                        state <= FCM_HS_SEQ;
                    end
                end
                FCM_HS_SEQ: begin
                    idx <= idx + 3'h1;
                    if (seq_end) begin
                        state <= (cmd == fcm_pkg::FCM_H_PROG) ? FCM_HS_DATA : FCM_HS_IDLE;
                        usr_done <= (cmd != fcm_pkg::FCM_H_PROG);
                    end
                end
                FCM_HS_DATA: begin
                    if (usr_wvalid) begin
                        cnt <= cnt + CNT_W'(1);
                        if (cnt == CNT_W'(PAGE_WORDS - 1)) begin
                            state <= FCM_HS_IDLE;
                            usr_done <= 1'b1;
                        end
                    end
                end
                FCM_HS_RD: begin
                    if (bus.rd_ack) begin
                        state <= FCM_HS_IDLE;
                    end
                end
                default: state <= FCM_HS_IDLE;
            endcase
        end
    end

    // Bus drive; every write is a full word, so wr_word is set whenever wr_valid is.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.wr_valid <= 1'b0;
            bus.wr_word <= 1'b0;
            bus.wr_addr <= 32'h0000_0000;
            bus.wr_data <= 32'h0000_0000;
            bus.rd_valid <= 1'b0;
            bus.rd_addr <= 32'h0000_0000;
        end else begin
            bus.wr_valid <= (state == FCM_HS_SEQ) || take_word;
            bus.wr_word <= (state == FCM_HS_SEQ) || take_word;
            bus.rd_valid <= (state == FCM_HS_IDLE) && !usr_req && usr_rd_req;
            if (state == FCM_HS_IDLE) begin
                bus.rd_addr <= usr_rd_addr;
            end
            if (state == FCM_HS_SEQ) begin
                bus.wr_addr <= s_addr;
                bus.wr_data <= s_data;
            end else if (take_word) begin
                bus.wr_addr <= taddr + {cnt, 2'b00};
                bus.wr_data <= usr_wdata;
            end
        end
    end
endmodule : fcm_host

// >>> fcm_link_asserts.sv
// Concurrent checks on the host to flash front end link.
// Assumes it watches the interface joining both design ends, on one clock.
`timescale 1ns/10ps
`include "fcm_cfg.svh"
module fcm_link_asserts (
    input logic clk,
    input logic rst_n,
    input logic wr_valid,
    input logic wr_word,
    input logic [31:0] wr_addr,
    input logic [31:0] wr_data,
    input logic rd_valid,
    input logic rd_ack,
    input logic [31:0] rd_data,
    input logic ready_busy_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Writes to the two unlock offsets, masked as the device does.
    wire w_c1 = wr_valid && (wr_addr & `FCM_ADDR_MASK) == `FCM_UNLOCK1_ADDR;
    wire w_c2 = wr_valid && (wr_addr & `FCM_ADDR_MASK) == `FCM_UNLOCK2_ADDR;

    // Each host sequence opens with a Read word, so it starts in read mode.
    sequence s_unlock;
        w_c1 && wr_data == `FCM_D_UNLOCK1 ##1 w_c2 && wr_data == `FCM_D_UNLOCK2;
    endsequence
    sequence s_open;
        ready_busy_flag && wr_valid && wr_data == `FCM_D_READ ##1 s_unlock;
    endsequence

    a_prog_busy: assert property (s_open ##1 w_c1 && wr_data == `FCM_D_PROG |=> !ready_busy_flag)
        else $error("program did not go busy");
    a_erase_busy: assert property (s_open ##1 w_c1 && wr_data == `FCM_D_ERASE ##1 s_unlock ##1
        wr_valid && (w_c1 && wr_data == `FCM_D_CHIP || wr_data == `FCM_D_BLOCK) |-> ##[1:2] !ready_busy_flag)
        else $error("erase did not start");
    a_prot_busy: assert property (s_open ##1 w_c1 && wr_data == `FCM_D_PROT ##1 s_unlock ##1
        wr_valid && wr_data == `FCM_D_PROT |-> ##[1:2] !ready_busy_flag)
        else $error("protect did not start");
    a_read_answer: assert property (rd_valid |-> ##2 rd_ack)
        else $error("read not answered");
    a_busy_blank: assert property (rd_valid && !ready_busy_flag ##1 !ready_busy_flag |-> ##1 rd_data == 32'h0)
        else $error("array data while busy");
    a_reset_ready: assert property ($rose(rst_n) |-> ready_busy_flag)
        else $error("not ready after reset");
    a_word_only: assert property (wr_valid |-> wr_word)
        else $error("write not a full word");
    a_flag_cause: assert property ($fell(ready_busy_flag) |-> $past(wr_valid) || $past(wr_valid, 2))
        else $error("busy without a write");
endmodule : fcm_link_asserts

// >>> testbench.sv
// Self-checking bench: host and device joined, and a second device fed faulty writes.
// Assumes the array reads back the inverted address and a page holds four words.
`timescale 1ns/10ps
`include "fcm_cfg.svh"
module testbench;
    localparam int PW = 4;
    logic clk = 1'b0, rst_n = 1'b0, usr_req = 1'b0, usr_wvalid = 1'b0, usr_rd_req = 1'b0;
    logic arr_done = 1'b0, arr_fail = 1'b0;
    fcm_pkg::fcm_hcmd_t usr_cmd = fcm_pkg::FCM_H_READ;
    logic [31:0] usr_addr = 32'h0, usr_wdata = 32'h0, usr_rd_addr = 32'h0;
    logic usr_ready, usr_done, usr_wready, usr_rd_ack, arr_rd_en, arr_wvalid, arr_start;
    logic [31:0] usr_rd_data, arr_rd_addr, arr_waddr, arr_wdata, arr_addr, top, last_addr;
    fcm_pkg::fcm_op_t arr_op, last_op;
    int n_mismatch = 0, checks = 0, n_start = 0, n_word = 0;
    fcm_if bus_a ();
    fcm_if bus_b ();
    wire [31:0] flag_a = {31'h0, bus_a.ready_busy_flag};

    fcm_host #(.PAGE_WORDS(PW)) u_fcm_host (.clk, .rst_n, .bus(bus_a), .usr_req, .usr_cmd, .usr_addr, .usr_ready,
        .usr_done, .usr_wvalid, .usr_wdata, .usr_wready, .usr_rd_req, .usr_rd_addr, .usr_rd_ack, .usr_rd_data);
    fcm_dev #(.PAGE_WORDS(PW)) u_fcm_dev (.clk, .rst_n, .bus(bus_a), .arr_rd_en, .arr_rd_addr,
        .arr_rdata(~arr_rd_addr), .arr_wvalid, .arr_waddr, .arr_wdata, .arr_start, .arr_op, .arr_addr, .arr_done,
        .arr_fail);
    // The second device never finishes; only reset frees it.
    fcm_dev #(.PAGE_WORDS(PW)) u_fcm_dev_b (.clk, .rst_n, .bus(bus_b), .arr_rd_en(), .arr_rd_addr(),
        .arr_rdata(32'h0), .arr_wvalid(), .arr_waddr(), .arr_wdata(), .arr_start(), .arr_op(), .arr_addr(),
        .arr_done(1'b0), .arr_fail(1'b0));
    fcm_link_asserts u_fcm_link_asserts (.clk, .rst_n, .wr_valid(bus_a.wr_valid),
        .wr_word(bus_a.wr_word), .wr_addr(bus_a.wr_addr), .wr_data(bus_a.wr_data), .rd_valid(bus_a.rd_valid),
        .rd_ack(bus_a.rd_ack), .rd_data(bus_a.rd_data), .ready_busy_flag(bus_a.ready_busy_flag));

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Array writes walk the page word by word; array reads only while the flag shows ready; starts are recorded.
    always @(posedge clk) begin
        if (arr_rd_en) begin
            check("arr_rd_en", flag_a, 32'h1);
        end
        if (arr_wvalid) begin
            check("arr_waddr", arr_waddr, top + 32'(n_word * 4));
            check("arr_wdata", arr_wdata, top ^ 32'(n_word));
            n_word <= n_word + 1;
        end
        if (arr_start) begin
            n_start <= n_start + 1;
            last_op <= arr_op;
            last_addr <= arr_addr;
        end
    end

    // One user command; page words are the page top xor the word index.
    task automatic cmd(input fcm_pkg::fcm_hcmd_t c, input logic [31:0] a);
        int i = 0;
        int k = 0;
        @(posedge clk);
        usr_req <= 1'b1;
        usr_cmd <= c;
        usr_addr <= a;
        top <= a;
        n_word <= 0;
        usr_wvalid <= (c == fcm_pkg::FCM_H_PROG);
        usr_wdata <= a;
        @(posedge clk);
        usr_req <= 1'b0;
        while (!usr_done && i < 300) begin
            @(posedge clk);
            i++;
            if (usr_wvalid && usr_wready) begin
                k++;
                usr_wdata <= a ^ 32'(k);
                usr_wvalid <= (k < PW);
            end
        end
        check("usr_done usr_ready", {30'h0, usr_done, usr_ready}, 32'h3);
    endtask : cmd

    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        int i = 0;
        @(posedge clk);
        usr_rd_req <= 1'b1;
        usr_rd_addr <= a;
        @(posedge clk);
        usr_rd_req <= 1'b0;
        while (!usr_rd_ack && i < 20) begin
            @(posedge clk);
            i++;
        end
        check(what, usr_rd_data, exp);
    endtask : rd

    // Runs an operation; the array finishes it soon after it starts.
    task automatic run(input fcm_pkg::fcm_hcmd_t c, input logic [31:0] a, input logic go, input fcm_pkg::fcm_op_t op);
        n_start = 0;
        cmd(c, a);
        repeat (4) @(posedge clk);
        check("arr_start", 32'(n_start), {31'h0, go});
        check("flag busy", flag_a, {31'h0, !go});
        if (go) begin
            check("arr_op", 32'(last_op), 32'(op));
            if (c != fcm_pkg::FCM_H_CHIP) begin
                check("arr_addr", last_addr, a);
            end
            rd("busy read", a, 32'h0);
            arr_done <= 1'b1;
            @(posedge clk);
            arr_done <= 1'b0;
            repeat (2) @(posedge clk);
        end
        check("flag ready", flag_a, 32'h1);
        rd("array read", a, ~a);
        $display("test command %0d finished", c);
    endtask : run

    // A released bus shows inverted values so stale data cannot pass.
    task automatic bw(input logic [31:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        bus_b.wr_valid <= 1'b1;
        bus_b.wr_addr <= a;
        bus_b.wr_data <= d;
        bus_b.wr_word <= w;
        @(posedge clk);
        bus_b.wr_valid <= 1'b0;
        bus_b.wr_addr <= ~a;
        bus_b.wr_data <= ~d;
    endtask : bw

    task automatic seq_b(input logic [31:0] a2, input logic w);
        bw(`FCM_UNLOCK1_ADDR, `FCM_D_UNLOCK1, 1'b1);
        bw(a2, `FCM_D_UNLOCK2, 1'b1);
        bw(`FCM_UNLOCK1_ADDR, `FCM_D_PROG, w);
    endtask : seq_b

    task automatic chk_b(input logic e);
        @(posedge clk);
        check("flag b", {31'h0, bus_b.ready_busy_flag}, {31'h0, e});
    endtask : chk_b

    // Cuts a hang short; the run needs a few hundred cycles.
    initial begin
        #50000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        bus_b.wr_valid = 1'b0;
        bus_b.rd_valid = 1'b0;
        bus_b.rd_addr = 32'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("flag after reset", flag_a, 32'h1);
        rd("read mode", 32'h0000_0100, ~32'h0000_0100);
        $display("test reset finished");
        run(fcm_pkg::FCM_H_PROG, 32'h0000_0200, 1'b1, fcm_pkg::FCM_OP_PROG);
        run(fcm_pkg::FCM_H_PROT, 32'h0000_8000, 1'b1, fcm_pkg::FCM_OP_PROT);
        run(fcm_pkg::FCM_H_PROG, 32'h0000_8200, 1'b0, fcm_pkg::FCM_OP_PROG);
        run(fcm_pkg::FCM_H_BLOCK, 32'h0001_0000, 1'b1, fcm_pkg::FCM_OP_BLOCK);
        run(fcm_pkg::FCM_H_CHIP, 32'h0000_5400, 1'b1, fcm_pkg::FCM_OP_CHIP);
        cmd(fcm_pkg::FCM_H_ID, 32'h0000_0300);
        rd("identifier_read_cmd", 32'h0000_0300, `FCM_ID_VALUE);
        rd("identifier_read_cmd again", 32'h0000_0304, `FCM_ID_VALUE);
        cmd(fcm_pkg::FCM_H_RESET, 32'h0000_0300);
        rd("after reset command", 32'h0000_0304, ~32'h0000_0304);
        cmd(fcm_pkg::FCM_H_ID, 32'h0000_0300);
        cmd(fcm_pkg::FCM_H_READ, 32'h0000_0c00);
        rd("after read command", 32'h0000_0308, ~32'h0000_0308);
        $display("test identifier finished");
        seq_b(`FCM_UNLOCK2_ADDR, 1'b0);
        chk_b(1'b1);
        seq_b(`FCM_UNLOCK1_ADDR, 1'b1);
        chk_b(1'b1);
        seq_b(`FCM_UNLOCK2_ADDR, 1'b1);
        chk_b(1'b0);
        bw(32'h0000_0040, `FCM_D_READ, 1'b1);
        chk_b(1'b0);
        $display("test faulty writes finished");
        cmd(fcm_pkg::FCM_H_CHIP, 32'h0);
        arr_fail <= 1'b1;
        repeat (20) @(posedge clk);
        check("flag locked", flag_a, 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        arr_fail <= 1'b0;
        @(posedge clk);
        check("flag a after reset", flag_a, 32'h1);
        check("flag b after reset", {31'h0, bus_b.ready_busy_flag}, 32'h1);
        rd("read after reset", 32'h0000_0400, ~32'h0000_0400);
        $display("test failure and reset finished");
        end_of_test();
    end
endmodule : testbench
